// ### hdl/gdio_port.sv
// general digital i/o port: apb register file, pad control and input sampling
//
// Summary of operation
// - ten registers: input pins, direction, output data, control, set/clear of direction and data, drive and pull status
// - input pins read only; data, direction read/write
// - writing one to input pins toggles data bit
// - global pull-up disable kills every pull-up
// - direction one means output, zero input
// - input with data one gets pull-up
// - all pins tri-stated while reset is active
// - output pin driven with its data bit
// - set/clear touch only the addressed pins
// - pull-up only for dir 0, data 1, enabled
// - alternate function leaves other pins as gpio
// - pad transitions reach input pins through synchroniser
// - written values read back through synchroniser
module gdio_port #(
   parameter int N = gdio_pkg::GDIO_PINS
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire gdio_pkg::gdio_apb_req_t apb_req,
   output gdio_pkg::gdio_apb_rsp_t     apb_rsp,
   input  wire logic [N-1:0]           pad_in,
   output logic [N-1:0]                pad_out,
   output logic [N-1:0]                pad_oe,
   output logic [N-1:0]                pad_pullup_en,
   input  wire logic [N-1:0]           af_sel,
   input  wire logic [N-1:0]           af_oe,
   input  wire logic [N-1:0]           af_out
);
   import gdio_pkg::*;

   // ==========================================================
   // declarations

   // register state, one bit per pin except the shared pull-up disable pud_q
   logic [N-1:0] dir_q;
   logic [N-1:0] dir_d;
   logic [N-1:0] out_q;
   logic [N-1:0] out_d;
   logic         pud_q;
   logic         pud_d;

   // bus side
   gdio_sel_t    sel;
   logic         setup;
   logic         wr_en;
   logic [N-1:0] wbits;
   logic [31:0]  rword;
   logic         rerr;
   logic [31:0]  prdata_q;
   logic         pslverr_q;

   // pad side
   logic [N-1:0] pin_sample;
   logic [N-1:0] gp_oe;
   logic [N-1:0] gp_pull;
   logic [N-1:0] eff_oe;
   logic [N-1:0] eff_out;
   logic [N-1:0] eff_pull;

   // ==========================================================
   // address decode

   // all eight bits of paddr are decoded; offsets off the map select nothing and error
   always_comb begin
      sel = GDIO_SEL_NONE;
      unique case (apb_req.paddr)
         GDIO_OFS_PINS:  sel = GDIO_SEL_PINS;
         GDIO_OFS_DIR:   sel = GDIO_SEL_DIR;
         GDIO_OFS_OUT:   sel = GDIO_SEL_OUT;
         GDIO_OFS_CTRL:  sel = GDIO_SEL_CTRL;
         GDIO_OFS_DSET:  sel = GDIO_SEL_DSET;
         GDIO_OFS_DCLR:  sel = GDIO_SEL_DCLR;
         GDIO_OFS_OSET:  sel = GDIO_SEL_OSET;
         GDIO_OFS_OCLR:  sel = GDIO_SEL_OCLR;
         GDIO_OFS_DRIVE: sel = GDIO_SEL_DRIVE;
         GDIO_OFS_PULL:  sel = GDIO_SEL_PULL;
         default:        sel = GDIO_SEL_NONE;
      endcase
   end

   // ==========================================================
   // apb handshake

   // the slave never stretches the access phase: pready is always high
   assign setup = apb_req.psel & ~apb_req.penable;
   assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite
                  & (sel != GDIO_SEL_NONE);
   assign wbits = apb_req.pwdata[N-1:0];

   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.prdata  = prdata_q;
   assign apb_rsp.pslverr = pslverr_q;

   // ==========================================================
   // read mux

   // narrow registers sit in the low bits, the rest reads zero
   always_comb begin
      rword = GDIO_RST_WORD;
      rerr  = 1'b0;
      unique case (sel)
         GDIO_SEL_PINS:  rword[N-1:0] = pin_sample;
         GDIO_SEL_DIR:   rword[N-1:0] = dir_q;
         GDIO_SEL_OUT:   rword[N-1:0] = out_q;
         GDIO_SEL_CTRL:  rword[GDIO_CTRL_PUD_BIT] = pud_q;
         GDIO_SEL_DSET:  rword[N-1:0] = dir_q;
         GDIO_SEL_DCLR:  rword[N-1:0] = dir_q;
         GDIO_SEL_OSET:  rword[N-1:0] = out_q;
         GDIO_SEL_OCLR:  rword[N-1:0] = out_q;
         GDIO_SEL_DRIVE: rword[N-1:0] = eff_oe;
         GDIO_SEL_PULL:  rword[N-1:0] = eff_pull;
         GDIO_SEL_NONE:  rerr = 1'b1;
      endcase
   end

   // read data is captured in the setup cycle so prdata comes from a flop;
   // a pad edge landing during the access cycle shows on the next read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= GDIO_RST_WORD;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q  <= apb_req.pwrite ? GDIO_RST_WORD : rword;
         pslverr_q <= rerr;
      end
   end

   // ==========================================================
   // direction register

   always_comb begin
      dir_d = dir_q;
      if (wr_en) begin
         unique case (sel)
            GDIO_SEL_DIR:  dir_d = wbits;
            GDIO_SEL_DSET: dir_d = dir_q | wbits;
            GDIO_SEL_DCLR: dir_d = dir_q & ~wbits;
            default:       dir_d = dir_q;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_q <= '0;
      end else begin
         dir_q <= dir_d;
      end
   end

   // ==========================================================
   // output data register

   // the toggle ignores direction, so it also flips a pull-up on or off
   always_comb begin
      out_d = out_q;
      if (wr_en) begin
         unique case (sel)
            GDIO_SEL_OUT:  out_d = wbits;
            GDIO_SEL_PINS: out_d = out_q ^ wbits;
            GDIO_SEL_OSET: out_d = out_q | wbits;
            GDIO_SEL_OCLR: out_d = out_q & ~wbits;
            default:       out_d = out_q;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q <= '0;
      end else begin
         out_q <= out_d;
      end
   end

   // ==========================================================
   // control register

   always_comb begin
      pud_d = pud_q;
      if (wr_en && sel == GDIO_SEL_CTRL) begin
         pud_d = apb_req.pwdata[GDIO_CTRL_PUD_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pud_q <= GDIO_RST_PUD;
      end else begin
         pud_q <= pud_d;
      end
   end

   // ==========================================================
   // pad control, one cell per pin

   // software alone must avoid glitching through 0b11 <-> 0b00 and
   // pull-up <-> low; the hardware applies each write as it comes
   for (genvar i = 0; i < N; i++) begin : g_pin
      // pin i is steered by its own bits and the shared pud_q
      assign gp_oe[i]   = dir_q[i];
      assign gp_pull[i] = ~dir_q[i] & out_q[i] & ~pud_q;

      // an alternate function takes only the pins it selects
      assign eff_oe[i]   = af_sel[i] ? af_oe[i]  : gp_oe[i];
      assign eff_out[i]  = af_sel[i] ? af_out[i] : out_q[i];
      assign eff_pull[i] = af_sel[i] ? 1'b0      : gp_pull[i];
   end

   // reset gates the pads directly so they float even with pclk stopped
   assign pad_oe        = eff_oe & {N{presetn}};
   assign pad_pullup_en = eff_pull & {N{presetn}};
   assign pad_out       = eff_out & {N{presetn}};

   // ==========================================================
   // input sampling

   // two flops replace the latch-plus-flop stage: a pad edge shows one to
   // two cycles later, a value software drives is seen two cycles after
   // the write, so software must wait two spare cycles before reading back
   gdio_sync #(
      .W        (N)
   ) u_sync (
      .clk      (pclk),
      .rst_n    (presetn),
      .async_in (pad_in),
      .sync_out (pin_sample)
   );

endmodule

// ### inc/gdio_pkg.sv
// package: register map, reset values and bus carriers of the digital i/o port
package gdio_pkg;

   // ==========================================================
   // sizes
   localparam int GDIO_PINS   = 6;
   localparam int GDIO_AW     = 8;
   localparam int GDIO_DW     = 32;
   localparam int GDIO_STAGES = 2;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] GDIO_OFS_PINS  = 8'h00;
   localparam logic [7:0] GDIO_OFS_DIR   = 8'h04;
   localparam logic [7:0] GDIO_OFS_OUT   = 8'h08;
   localparam logic [7:0] GDIO_OFS_CTRL  = 8'h0c;
   localparam logic [7:0] GDIO_OFS_DSET  = 8'h10;
   localparam logic [7:0] GDIO_OFS_DCLR  = 8'h14;
   localparam logic [7:0] GDIO_OFS_OSET  = 8'h18;
   localparam logic [7:0] GDIO_OFS_OCLR  = 8'h1c;
   localparam logic [7:0] GDIO_OFS_DRIVE = 8'h20;
   localparam logic [7:0] GDIO_OFS_PULL  = 8'h24;

   // ==========================================================
   // fields and reset values
   localparam int         GDIO_CTRL_PUD_BIT = 0;
   localparam logic       GDIO_RST_PUD      = 1'b0;
   localparam logic [31:0] GDIO_RST_WORD    = 32'h0000_0000;

   // ==========================================================
   // register select decoded from the address
   typedef enum logic [3:0] {
      GDIO_SEL_PINS  = 4'b0000,
      GDIO_SEL_DIR   = 4'b0001,
      GDIO_SEL_OUT   = 4'b0010,
      GDIO_SEL_CTRL  = 4'b0011,
      GDIO_SEL_DSET  = 4'b0100,
      GDIO_SEL_DCLR  = 4'b0101,
      GDIO_SEL_OSET  = 4'b0110,
      GDIO_SEL_OCLR  = 4'b0111,
      GDIO_SEL_DRIVE = 4'b1000,
      GDIO_SEL_PULL  = 4'b1001,
      GDIO_SEL_NONE  = 4'b1111
   } gdio_sel_t;

   // ==========================================================
   // apb carriers
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } gdio_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } gdio_apb_rsp_t;

endpackage

// ### hdl/gdio_sync.sv
// two-stage synchroniser for the asynchronous pad inputs
module gdio_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] async_in,
   output logic [W-1:0]      sync_out
);
   import gdio_pkg::*;

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // ==========================================================
   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

// ### verification/gdio_port_monitor.sv
// assertion checker for the pad controls and apb answers of the port
module gdio_port_monitor
   import gdio_pkg::*;
#(
   parameter int N = GDIO_PINS
) (
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire gdio_pkg::gdio_apb_req_t apb_req,
   input wire gdio_pkg::gdio_apb_rsp_t apb_rsp,
   input wire logic [N-1:0]            pad_in,
   input wire logic [N-1:0]            pad_out,
   input wire logic [N-1:0]            pad_oe,
   input wire logic [N-1:0]            pad_pullup_en,
   input wire logic [N-1:0]            af_sel,
   input wire logic [N-1:0]            af_oe,
   input wire logic [N-1:0]            af_out
);
   // ==========================================================
   // helpers
   logic         wr;
   logic [N-1:0] d;
   logic [N-1:0] g;
   logic [7:0]   a;
   assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign d  = apb_req.pwdata[N-1:0];
   assign g  = ~af_sel;
   assign a  = apb_req.paddr;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // assertions
   a_reset_tristate: assert property (
      disable iff (1'b0) !presetn |-> !(pad_oe | pad_pullup_en)) else $error("pad on in reset");
   a_pull_excl: assert property (
      (pad_oe & pad_pullup_en) == '0) else $error("pull-up on output");
   a_af_owns: assert property (
      ((pad_oe ^ af_oe) & af_sel) == '0 && (pad_pullup_en & af_sel) == '0)
      else $error("alternate pin wrong");
   a_dir_write: assert property (
      wr && a == GDIO_OFS_DIR |=> ((pad_oe ^ $past(d)) & g) == '0) else $error("dir write");
   a_out_write: assert property (
      wr && a == GDIO_OFS_OUT |=> ((pad_out ^ $past(d)) & pad_oe & g) == '0)
      else $error("out write");
   a_pin_toggle: assert property (
      wr && a == GDIO_OFS_PINS |=> $stable(pad_oe) &&
      ((pad_out ^ $past(pad_out) ^ $past(d)) & pad_oe & g) == '0) else $error("toggle");
   a_dir_set: assert property (
      wr && a == GDIO_OFS_DSET |=> ((pad_oe ^ ($past(pad_oe) | $past(d))) & g) == '0)
      else $error("dir set");
   a_dir_clr: assert property (
      wr && a == GDIO_OFS_DCLR |=> ((pad_oe ^ ($past(pad_oe) & ~$past(d))) & g) == '0)
      else $error("dir clear");
   a_pud_kill: assert property (
      wr && a == GDIO_OFS_CTRL && apb_req.pwdata[0] |=> pad_pullup_en == '0)
      else $error("pull-up not off");
   a_bad_addr: assert property (
      apb_req.psel && !apb_req.penable && a > GDIO_OFS_PULL |=> apb_rsp.pslverr)
      else $error("no slave error");
   c_toggle: cover property (wr && a == GDIO_OFS_PINS);
   c_alt:    cover property (|(af_sel & af_oe));
   c_err:    cover property (apb_rsp.pslverr);
endmodule

// ### verification/gdio_pad_model.sv
// board model: loads and an optional external driver on each pad
module gdio_pad_model #(
   parameter int N = 6
) (
   input  wire logic         pclk,
   input  wire logic [N-1:0] pad_out,
   input  wire logic [N-1:0] pad_oe,
   input  wire logic [N-1:0] pad_pullup_en,
   input  wire logic [N-1:0] ext_en,
   input  wire logic [N-1:0] ext_val,
   output logic [N-1:0]      pad_lvl
);
   // a floating pad wanders every cycle so no stale level can pass a check
   logic flip_q = 1'b0;
   always @(posedge pclk) flip_q <= ~flip_q;
   always_comb begin
      for (int i = 0; i < N; i++) begin
         if (pad_oe[i]) pad_lvl[i] = pad_out[i];
         else if (ext_en[i]) pad_lvl[i] = ext_val[i];
         else if (pad_pullup_en[i]) pad_lvl[i] = 1'b1;
         else pad_lvl[i] = flip_q;
      end
   end
endmodule

// ### verification/gdio_port_test.sv
// self-checking bench for the digital i/o port
module gdio_port_test
   import gdio_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int N = GDIO_PINS;
   logic          pclk, presetn;
   gdio_apb_req_t req;
   gdio_apb_rsp_t rsp;
   logic [N-1:0]  pad_in, pad_out, pad_oe, pad_pu, af_sel, af_oe, af_out, ext_en, ext_val;
   int            error_cnt = 0;
   int            tests_run = 0;
   gdio_port #(.N(N)) u_gdio_port (.pclk(pclk), .presetn(presetn), .apb_req(req),
      .apb_rsp(rsp), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pullup_en(pad_pu), .af_sel(af_sel), .af_oe(af_oe), .af_out(af_out));
   gdio_pad_model #(.N(N)) u_gdio_pad_model (.pclk(pclk), .pad_out(pad_out),
      .pad_oe(pad_oe), .pad_pullup_en(pad_pu), .ext_en(ext_en), .ext_val(ext_val),
      .pad_lvl(pad_in));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // ==========================================================
   // bus and check tasks
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk("pready", 1, 0);
         tally_and_finish();
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(negedge pclk);
   endtask
   task automatic w(logic [7:0] a, logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rc(logic [7:0] a, logic [31:0] exp, string what);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(what, exp, r);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_drive();
      ext_en <= 6'h20;
      ext_val <= 6'h20;
      w(GDIO_OFS_OUT, 32'h13);
      chk("pull", 6'h13, pad_pu);
      w(GDIO_OFS_DIR, 32'h0f);
      chk("oe", 6'h0f, pad_oe);
      chk("drive", 6'h03, pad_out & pad_oe);
      chk("pull", 6'h10, pad_pu);
      rc(GDIO_OFS_DIR, 32'h0f, "dir");
      rc(GDIO_OFS_PINS, 32'h33, "pins");
      w(GDIO_OFS_PINS, 32'h05);
      rc(GDIO_OFS_OUT, 32'h16, "toggle");
      $display("drive and toggle done");
   endtask
   task automatic t_setclr();
      ext_en <= 6'h00;
      w(GDIO_OFS_DSET, 32'h30);
      w(GDIO_OFS_DCLR, 32'h01);
      rc(GDIO_OFS_DIR, 32'h3e, "dirsc");
      w(GDIO_OFS_OSET, 32'h01);
      w(GDIO_OFS_OCLR, 32'h04);
      rc(GDIO_OFS_OUT, 32'h13, "outsc");
      $display("set and clear done");
   endtask
   task automatic t_pud();
      w(GDIO_OFS_DIR, 32'h0);
      w(GDIO_OFS_OUT, 32'h3f);
      w(GDIO_OFS_CTRL, 32'h1);
      chk("pud", 6'h00, pad_pu);
      rc(GDIO_OFS_CTRL, 32'h1, "ctrl");
      w(GDIO_OFS_CTRL, 32'h0);
      chk("pullall", 6'h3f, pad_pu);
      @(posedge pclk);
      af_sel <= 6'h01;
      af_oe <= 6'h01;
      @(negedge pclk);
      chk("af", 6'h3e, pad_pu);
      rc(GDIO_OFS_PULL, 32'h3e, "pullreg");
      rc(GDIO_OFS_DRIVE, 32'h01, "drivereg");
      $display("pull-up and alternate done");
   endtask
   task automatic t_err();
      logic [31:0] r;
      logic        e;
      apb(1'b0, 8'h30, 32'h0, r, e);
      chk("slverr", 1, e);
      chk("baddata", 0, r);
      w(GDIO_OFS_DIR, 32'h3f);
      @(posedge pclk);
      presetn <= 1'b0;
      #1;
      chk("rst oe", 6'h00, pad_oe);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rc(GDIO_OFS_DIR, 32'h0, "dir rst");
      $display("error and reset done");
   endtask
   initial begin
      req = '0;
      presetn = 1'b0;
      {af_sel, af_oe, af_out, ext_en, ext_val} = '0;
      repeat (16) @(posedge pclk);
      chk("rst pads", 6'h00, pad_oe | pad_pu);
      presetn <= 1'b1;
      t_drive();
      t_setclr();
      t_pud();
      t_err();
      tally_and_finish();
   end
endmodule
bind gdio_port gdio_port_monitor #(.N(N)) u_gdio_port_monitor (.pclk(pclk),
   .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .pad_in(pad_in),
   .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
   .af_sel(af_sel), .af_oe(af_oe), .af_out(af_out));
